//--- hdl/wtu_top.sv
// Watchdog timer unit with APB register access
`timescale 1ns/1ps
`default_nettype none
module wtu_top
  import wtu_pkg::*;
#(
  parameter int unsigned SLOW_DIV = SLOW_DIV_CYCLES
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire wtu_apb_req_t apbReq,
  output var  wtu_apb_rsp_t apbRsp,
  input  wire logic         wdClearInstr,
  input  wire logic         powerSaveInstr,
  input  wire logic         powerSaveIdle,
  input  wire logic         wakeEvent,
  input  wire logic         oscSwitchDone,
  input  wire logic         failSafeSwitchDone,
  input  wire logic         sysReset,
  output logic              lowPowerRcOscEn,
  output logic              wdResetOut,
  output logic              wdWakeOut,
  output logic              inSleep,
  output logic              inIdle
);

  // ****************************************************************
  // Window arithmetic
  // ****************************************************************
  // Position and period in slow ticks, so codes 0 and 1 keep exact quarters
  function automatic logic windowOpen(input logic [POST_W-1:0] post, input logic [PRE_W-1:0] pre,
                                      input logic preSel, input logic [3:0] postSel);
    logic [WIN_W-1:0] preDiv;
    logic [WIN_W-1:0] pos;
    logic [WIN_W-1:0] total;
    preDiv = preSel ? WIN_W'(PRE_LONG_DIV) : WIN_W'(PRE_SHORT_DIV);
    pos    = WIN_W'(WIN_W'(post) * preDiv) + WIN_W'(pre);
    total  = preDiv << postSel;
    windowOpen = WIN_W'(pos << 2) >= WIN_W'(total * WIN_W'(3));
  endfunction : windowOpen

  // ****************************************************************
  // State
  // ****************************************************************
  wtu_cfg_t          cfg_reg,       cfg_next;
  wtu_pwr_state_t    pwr_reg,       pwr_next;
  logic [PRE_W-1:0]  pre_reg,       pre_next;
  logic [POST_W-1:0] post_reg,      post_next;
  logic              softEn_reg,    softEn_next;
  logic              timeout_reg,   timeout_next;
  logic              sleepSt_reg,   sleepSt_next;
  logic              idleSt_reg,    idleSt_next;
  logic              wdReset_reg,   wdReset_next;
  logic              wdWake_reg,    wdWake_next;
  logic [31:0]       prdata_reg,    prdata_next;
  logic              pslverr_reg,   pslverr_next;

  logic              wdEnabled;
  logic              divTick;
  logic [PRE_W-1:0]  preLast;
  logic [POST_W-1:0] postLast;
  logic              preTick;
  logic              expire;
  logic              runClr;
  logic              earlyClr;
  logic              psEntry;
  logic              psExit;
  logic              wdogReset;
  logic              devReset;
  logic              countClr;
  logic              setupPh;
  logic              accessPh;
  logic              hitCfg;
  logic              hitRc;
  logic              wrCfg;
  logic              wrRc;
  logic [31:0]       cfgWord;
  logic [31:0]       rcWord;

  // ****************************************************************
  // Enable and slow clock
  // ****************************************************************
  // always-on overrides
  assign wdEnabled       = cfg_reg.alwaysOn || softEn_reg;
  assign lowPowerRcOscEn = wdEnabled;

  wtu_tick_div #(.DIV(SLOW_DIV)) u_tick (
    .mclk  (mclk),
    .rst   (rst),
    .run   (wdEnabled),
    .clear (countClr),
    .tick  (divTick)
  );

  // ****************************************************************
  // Count decode
  // ****************************************************************
  // divide by 32 or 128
  assign preLast  = cfg_reg.prescaleSelect ? PRE_W'(PRE_LONG_DIV - 1) : PRE_W'(PRE_SHORT_DIV - 1);
  // code 1111 is the longest ratio
  assign postLast = 15'h7fff >> (4'hf - cfg_reg.postscaleSelect);
  assign preTick  = divTick && (pre_reg == preLast) &&
                    !(sysReset || earlyClr || oscSwitchDone || failSafeSwitchDone || psEntry || runClr);
  assign expire   = wdEnabled && preTick && (post_reg == postLast);

  assign runClr    = (pwr_reg == PWR_RUN) && wdClearInstr;
  assign earlyClr  = runClr && wdEnabled && !cfg_reg.windowDisable &&
                     !windowOpen(post_reg, pre_reg, cfg_reg.prescaleSelect, cfg_reg.postscaleSelect);
  assign psEntry   = (pwr_reg == PWR_RUN) && powerSaveInstr;
  assign psExit    = (pwr_reg != PWR_RUN) && (wakeEvent || expire);
  assign wdogReset = ((pwr_reg == PWR_RUN) && expire) || earlyClr;
  assign devReset  = sysReset || wdogReset;
  assign countClr  = devReset || oscSwitchDone || failSafeSwitchDone || psEntry || psExit || runClr || !wdEnabled;

  // ****************************************************************
  // Prescaler, postscaler and power state
  // ****************************************************************
  always_comb begin
    pre_next    = pre_reg;
    post_next   = post_reg;
    pwr_next    = pwr_reg;
    wdWake_next = (pwr_reg != PWR_RUN) && expire;
    if (countClr) begin
      pre_next  = '0;
      post_next = '0;
    end else if (divTick) begin
      if (preTick) begin
        pre_next  = '0;
        post_next = post_reg + POST_W'(1);
      end else begin
        pre_next  = pre_reg + PRE_W'(1);
      end
    end
    case (pwr_reg)
      PWR_RUN: begin
        if (psEntry && !devReset) begin
          pwr_next = powerSaveIdle ? PWR_IDLE : PWR_SLEEP;
        end
      end
      PWR_SLEEP, PWR_IDLE: begin
        if (psExit || devReset) begin
          pwr_next = PWR_RUN;
        end
      end
      default: begin
        pwr_next = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_reg    <= '0;
      post_reg   <= '0;
      pwr_reg    <= PWR_RUN;
      wdWake_reg <= 1'b0;
    end else begin
      pre_reg    <= pre_next;
      post_reg   <= post_next;
      pwr_reg    <= pwr_next;
      wdWake_reg <= wdWake_next;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Zero wait states; read data is captured in the setup cycle
  assign setupPh  = apbReq.psel && !apbReq.penable;
  assign accessPh = apbReq.psel && apbReq.penable;
  assign hitCfg   = apbReq.paddr == REG_CONFIG_OFS;
  assign hitRc    = apbReq.paddr == REG_RESET_CTRL_OFS;
  assign wrCfg    = accessPh && apbReq.pwrite && hitCfg;
  assign wrRc     = accessPh && apbReq.pwrite && hitRc;

  always_comb begin
    cfgWord = '0;
    cfgWord[CFG_POST_LSB +: CFG_POST_W] = cfg_reg.postscaleSelect;
    cfgWord[CFG_PRE_BIT]                = cfg_reg.prescaleSelect;
    cfgWord[CFG_WINOFF_BIT]             = cfg_reg.windowDisable;
    cfgWord[CFG_ALWAYS_ON_BIT]          = cfg_reg.alwaysOn;
    rcWord = '0;
    rcWord[RC_IDLE_BIT]                 = idleSt_reg;
    rcWord[RC_SLEEP_BIT]                = sleepSt_reg;
    rcWord[RC_TIMEOUT_BIT]              = timeout_reg;
    rcWord[RC_SOFT_EN_BIT]              = softEn_reg;
  end

  always_comb begin
    cfg_next     = cfg_reg;
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    wdReset_next = wdogReset;
    if (setupPh) begin
      prdata_next  = hitCfg ? cfgWord : (hitRc ? rcWord : 32'h0000_0000);
      pslverr_next = !(hitCfg || hitRc);
    end
    if (wrCfg) begin
      cfg_next.postscaleSelect = apbReq.pwdata[CFG_POST_LSB +: CFG_POST_W];
      cfg_next.prescaleSelect  = apbReq.pwdata[CFG_PRE_BIT];
      cfg_next.windowDisable   = apbReq.pwdata[CFG_WINOFF_BIT];
      cfg_next.alwaysOn        = apbReq.pwdata[CFG_ALWAYS_ON_BIT];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    softEn_next  = wrRc ? apbReq.pwdata[RC_SOFT_EN_BIT] : softEn_reg;
    if (devReset) begin
      softEn_next = 1'b0;
    end
    timeout_next = expire || earlyClr || (wrRc ? apbReq.pwdata[RC_TIMEOUT_BIT] : timeout_reg);
    sleepSt_next = (psEntry && !powerSaveIdle) || (wrRc ? apbReq.pwdata[RC_SLEEP_BIT] : sleepSt_reg);
    idleSt_next  = (psEntry && powerSaveIdle) || (wrRc ? apbReq.pwdata[RC_IDLE_BIT] : idleSt_reg);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_reg     <= wtu_cfg_t'({CFG_RESET[CFG_ALWAYS_ON_BIT], CFG_RESET[CFG_WINOFF_BIT],
                                 CFG_RESET[CFG_PRE_BIT], CFG_RESET[CFG_POST_LSB +: CFG_POST_W]});
      softEn_reg  <= RC_RESET[RC_SOFT_EN_BIT];
      timeout_reg <= RC_RESET[RC_TIMEOUT_BIT];
      sleepSt_reg <= RC_RESET[RC_SLEEP_BIT];
      idleSt_reg  <= RC_RESET[RC_IDLE_BIT];
      wdReset_reg <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      softEn_reg  <= softEn_next;
      timeout_reg <= timeout_next;
      sleepSt_reg <= sleepSt_next;
      idleSt_reg  <= idleSt_next;
      wdReset_reg <= wdReset_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = pslverr_reg;
  assign apbRsp.prdata  = prdata_reg;
  assign wdResetOut     = wdReset_reg;
  assign wdWakeOut      = wdWake_reg;
  assign inSleep        = pwr_reg == PWR_SLEEP;
  assign inIdle         = pwr_reg == PWR_IDLE;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Cycles between prescaler outputs, valid only across an undisturbed period
  int unsigned gapCnt;
  logic        gapValid;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gapCnt   <= 0;
      gapValid <= 1'b0;
    end else begin
      gapCnt   <= (preTick || countClr) ? 0 : gapCnt + 1;
      gapValid <= (countClr || (accessPh && apbReq.pwrite)) ? 1'b0 : (preTick ? 1'b1 : gapValid);
    end
  end

  a_osc_forced_on:     assert property (cfg_reg.alwaysOn |-> lowPowerRcOscEn)
    else $error("Oscillator off while watchdog always on");
  a_prescale_period:   assert property (preTick && gapValid |->
                         gapCnt == SLOW_DIV * (cfg_reg.prescaleSelect ? PRE_LONG_DIV : PRE_SHORT_DIV) - 1)
    else $error("Prescaler period wrong");
  a_post_ratio:        assert property (expire |-> post_reg == POST_W'((1 << cfg_reg.postscaleSelect) - 1))
    else $error("Postscaler expired at wrong count");
  a_reset_clears:      assert property (sysReset |=> pre_reg == '0 && post_reg == '0 && !softEn_reg)
    else $error("Device reset did not clear counts");
  a_switch_clears:     assert property ((oscSwitchDone || failSafeSwitchDone) |=> pre_reg == '0 && post_reg == '0)
    else $error("Clock switch did not clear counts");
  a_entry_clears:      assert property (psEntry && !devReset |=> pwr_reg != PWR_RUN && pre_reg == '0
                         && (sleepSt_reg || idleSt_reg))
    else $error("Power-save entry wrong");
  a_wake_on_expire:    assert property (pwr_reg != PWR_RUN && expire |=> pwr_reg == PWR_RUN && wdWakeOut
                         && timeout_reg && !wdResetOut && post_reg == '0)
    else $error("Time-out in power save did not wake");
  a_clear_instr:       assert property (runClr |=> pre_reg == '0 && post_reg == '0)
    else $error("Clear instruction ignored");
  a_flag_sticky:       assert property (timeout_reg && !wrRc |=> timeout_reg)
    else $error("Time-out flag dropped without software");
  a_soft_disabled:     assert property (!cfg_reg.alwaysOn && !softEn_reg |-> !lowPowerRcOscEn && !expire)
    else $error("Watchdog ran while disabled");
  a_window_early:      assert property (earlyClr |=> wdResetOut && timeout_reg ##1 !wdResetOut)
    else $error("Early clear did not reset");
  a_run_expire:        assert property (pwr_reg == PWR_RUN && expire |=> wdResetOut && timeout_reg
                         && !softEn_reg)
    else $error("Time-out in run did not reset");
  a_nonwindow_clear:   assert property (runClr && cfg_reg.windowDisable |=> !wdResetOut)
    else $error("Clear in non-window mode caused reset");

  c_run_reset:  cover property (pwr_reg == PWR_RUN && expire);
  c_sleep_wake: cover property (inSleep && expire ##1 wdWakeOut);
  c_early_clr:  cover property (earlyClr);
  c_late_clr:   cover property (runClr && !cfg_reg.windowDisable && !earlyClr);
endmodule : wtu_top
`default_nettype wire

//--- hdl/wtu_pkg.sv
// Package of constants and types for the watchdog timer unit
`default_nettype none
package wtu_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned MCLK_FREQ_HZ        = 100_000_000;
  localparam int unsigned SLOW_FREQ_HZ        = 32_000;
  localparam int unsigned PRE_SHORT_DIV       = 32;
  localparam int unsigned PRE_LONG_DIV        = 128;
  localparam int unsigned PRE_SHORT_PERIOD_US = 1000;
  localparam int unsigned PRE_LONG_PERIOD_US  = 4000;
  // Mclk cycles per slow-clock tick, from the nominal 1 ms prescaler period
  localparam int unsigned SLOW_DIV_CYCLES     = (PRE_SHORT_PERIOD_US * (MCLK_FREQ_HZ / 1_000_000)) / PRE_SHORT_DIV;
  localparam int unsigned PRE_W               = 7;
  localparam int unsigned POST_W              = 15;
  localparam int unsigned WIN_W               = 25;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W              = 12;
  localparam logic [11:0] REG_CONFIG_OFS      = 12'h000;
  localparam logic [11:0] REG_RESET_CTRL_OFS  = 12'h004;

  localparam int unsigned CFG_POST_LSB        = 0;
  localparam int unsigned CFG_POST_W          = 4;
  localparam int unsigned CFG_PRE_BIT         = 4;
  localparam int unsigned CFG_WINOFF_BIT      = 6;
  localparam int unsigned CFG_ALWAYS_ON_BIT   = 7;
  localparam logic [31:0] CFG_RESET           = 32'h0000_004f;

  localparam int unsigned RC_IDLE_BIT         = 2;
  localparam int unsigned RC_SLEEP_BIT        = 3;
  localparam int unsigned RC_TIMEOUT_BIT      = 4;
  localparam int unsigned RC_SOFT_EN_BIT      = 5;
  localparam logic [31:0] RC_RESET            = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_IDLE} wtu_pwr_state_t;

  typedef struct packed {
    logic              alwaysOn;
    logic              windowDisable;
    logic              prescaleSelect;
    logic [3:0]        postscaleSelect;
  } wtu_cfg_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } wtu_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } wtu_apb_rsp_t;

endpackage : wtu_pkg
`default_nettype wire

//--- hdl/wtu_tick_div.sv
// Divider that makes the slow watchdog clock as a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
module wtu_tick_div #(
  parameter int unsigned DIV = 3125
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic clear,
  output logic      tick
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Clearing restarts the slow phase so every count period is whole
  always_comb begin
    cnt_next = cnt_reg;
    if (clear || !run) begin
      cnt_next = '0;
    end else if (cnt_reg == LAST) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Tick ignores clear; the parent masks it, as the parent's clear depends on the tick
  assign tick = run && (cnt_reg == LAST);

endmodule : wtu_tick_div
`default_nettype wire

//--- tb/wtu_core_model.sv
// Core model issuing watchdog instruction pulses
`timescale 1ns/1ps
`default_nettype none
module wtu_core_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       opGo,
  input  wire logic [2:0] opCode,
  output logic            wdClearInstr,
  output logic            powerSaveInstr,
  output logic            powerSaveIdle,
  output logic            wakeEvent,
  output logic            oscSwitchDone,
  output logic            failSafeSwitchDone
);
  // **********
  // Ops: 0 clear, 1 sleep, 2 idle, 3 wake, 4 switch, 5 fail-safe
  // **********
  wire logic ps = opGo && (opCode == 3'h1 || opCode == 3'h2);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {wdClearInstr, powerSaveInstr, powerSaveIdle, wakeEvent, oscSwitchDone, failSafeSwitchDone} <= '0;
    end else begin
      wdClearInstr       <= opGo && opCode == 3'h0;
      powerSaveInstr     <= ps;
      // Toggles when unqualified, so a stale level is never trusted
      powerSaveIdle      <= ps ? opCode == 3'h2 : ~powerSaveIdle;
      wakeEvent          <= opGo && opCode == 3'h3;
      oscSwitchDone      <= opGo && opCode == 3'h4;
      failSafeSwitchDone <= opGo && opCode == 3'h5;
    end
  end
endmodule : wtu_core_model
`default_nettype wire

//--- tb/watchdog_timer_unit_bench.sv
// Self-checking bench for the watchdog timer unit
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit_bench
  import wtu_pkg::*;
;
  localparam int unsigned DIV = 2;
  localparam logic [11:0] CFG = REG_CONFIG_OFS;
  localparam logic [11:0] RC  = REG_RESET_CTRL_OFS;
  logic         mclk, rst, opGo, sysReset, slvErr, gotWake;
  logic [2:0]   opCode;
  wtu_apb_req_t apbReq;
  wtu_apb_rsp_t apbRsp;
  logic         wdClr, psInstr, psIdle, wake, oscDone, fsDone;
  logic         rcEn, wdRst, wdWake, inSleep, inIdle;
  logic [31:0]  rd;
  int           errors, tests_run, n, cycles = 0;
  logic [3:0]   post [4] = '{4'h0, 4'h0, 4'h1, 4'h2};
  logic         pres [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  wtu_core_model cpu (.mclk(mclk), .rst(rst), .opGo(opGo), .opCode(opCode), .wdClearInstr(wdClr),
    .powerSaveInstr(psInstr), .powerSaveIdle(psIdle), .wakeEvent(wake), .oscSwitchDone(oscDone),
    .failSafeSwitchDone(fsDone));
  wtu_top #(.SLOW_DIV(DIV)) dut (.mclk(mclk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .wdClearInstr(wdClr), .powerSaveInstr(psInstr), .powerSaveIdle(psIdle), .wakeEvent(wake),
    .oscSwitchDone(oscDone), .failSafeSwitchDone(fsDone), .sysReset(sysReset), .lowPowerRcOscEn(rcEn),
    .wdResetOut(wdRst), .wdWakeOut(wdWake), .inSleep(inSleep), .inIdle(inIdle));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // **********
  // Tasks
  // **********
  task automatic results();
    $display("Checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : chk

  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge mclk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    slvErr = apbRsp.pslverr;
    apbReq <= '0;
    #1;
  endtask : apb

  // The design takes the pulse at the edge after this returns
  task automatic op(input logic [2:0] code);
    @(posedge mclk);
    opGo   <= 1'b1;
    opCode <= code;
    @(posedge mclk);
    opGo <= 1'b0;
  endtask : op

  // Design takes the reset at the edge where this returns, one earlier than op
  task automatic sysRst();
    @(posedge mclk);
    sysReset <= 1'b1;
    @(posedge mclk);
    sysReset <= 1'b0;
  endtask : sysRst

  task automatic waitOut(input int limit);
    n = 0;
    gotWake = 1'b0;
    for (int i = 1; i <= limit && n == 0; i++) begin
      @(posedge mclk);
      #1;
      if (wdRst === 1'b1 || wdWake === 1'b1) begin
        n = i;
        gotWake = wdWake;
      end
    end
  endtask : waitOut

  task automatic expectOut(input string what, input int p, input logic wk);
    waitOut(p + 8);
    chk(what, p, (n >= p && n <= p + 2) ? p : n);
    chk("out kind", wk, gotWake);
  endtask : expectOut

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error run limit expected done seen hung");
      results();
    end
  end

  // **********
  // Tests
  // **********
  initial begin
    apbReq = '0;
    opGo = 1'b0;
    opCode = 3'h0;
    sysReset = 1'b0;
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, CFG, 32'h0);
    chk("config", 32'h0000_004f, rd);
    apb(1'b0, RC, 32'h0);
    chk("reset ctrl", 32'h0, rd);
    chk("osc en", 1'b0, rcEn);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 1'b1, slvErr);
    $display("Test reset done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, CFG, {24'h0, 1'b0, 1'b1, 1'b0, pres[k], post[k]});
      apb(1'b1, RC, 32'h0000_0020);
      chk("osc en", 1'b1, rcEn);
      op(3'h0);
      expectOut("period", DIV * (pres[k] ? PRE_LONG_DIV : PRE_SHORT_DIV) * (1 << post[k]), 1'b0);
      apb(1'b0, RC, 32'h0);
      chk("flags", 32'h0000_0010, rd);
    end
    $display("Test periods done");
    apb(1'b1, CFG, 32'h0000_0040);
    apb(1'b1, RC, 32'h0000_0020);
    for (int k = 0; k < 3; k++) begin
      op(k == 0 ? 3'h0 : 3'(3 + k));
      waitOut(40);
      chk("early out", 0, n);
    end
    op(3'h5);
    expectOut("switch", 64, 1'b0);
    $display("Test clears done");
    for (int k = 1; k <= 2; k++) begin
      apb(1'b1, RC, 32'h0000_0020);
      op(3'h0);
      waitOut(30);
      op(3'(k));
      expectOut("power save", 64, 1'b1);
      apb(1'b0, RC, 32'h0);
      chk("status", 32'h0000_0030 | (k == 1 ? 32'h8 : 32'h4), rd);
      chk("awake", 2'b00, {inSleep, inIdle});
      op(3'(k));
      waitOut(20);
      chk("asleep", k == 1 ? 2'b10 : 2'b01, {inSleep, inIdle});
      op(3'h3);
      expectOut("after wake", 64, 1'b0);
    end
    $display("Test power save done");
    apb(1'b1, CFG, 32'h0);
    apb(1'b1, RC, 32'h0000_0020);
    op(3'h0);
    expectOut("early clear", 1, 1'b0);
    apb(1'b1, RC, 32'h0000_0020);
    waitOut(50);
    chk("late clear", 0, n);
    op(3'h0);
    expectOut("window", 64, 1'b0);
    $display("Test window done");
    apb(1'b1, CFG, 32'h0000_0040);
    apb(1'b1, RC, 32'h0000_0020);
    sysRst();
    apb(1'b0, RC, 32'h0);
    chk("soft en", 32'h0, rd);
    op(3'h0);
    waitOut(200);
    chk("disabled", 0, n);
    apb(1'b1, CFG, 32'h0000_00c0);
    chk("osc on", 1'b1, rcEn);
    op(3'h0);
    waitOut(40);
    sysRst();
    expectOut("dev reset", 63, 1'b0);
    $display("Test enables done");
    results();
  end
endmodule : watchdog_timer_unit_bench
`default_nettype wire
